/* File: verilog/arsel_pkg.sv */
// constants, types and field layout of the converter result and input select block
package arsel_pkg;
  // ==========================================
  // register offsets
  localparam logic [2:0] OFF_CTRL_A = 3'h0;
  localparam logic [2:0] OFF_CTRL_B = 3'h1;
  localparam logic [2:0] OFF_SELECT = 3'h2;
  localparam logic [2:0] OFF_RES_LO = 3'h3;
  localparam logic [2:0] OFF_RES_HI = 3'h4;
  // ==========================================
  // control/status a fields
  localparam int CA_ENABLE = 7;
  localparam int CA_START = 6;
  localparam int CA_DONE = 4;
  localparam int CA_DONE_MASK = 3;
  // ==========================================
  // control/status b fields
  localparam int CB_AMP_SHORT = 0;
  // ==========================================
  // reset values and select write mask
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_SELECT = 8'h00;
  localparam logic [9:0] RST_RESULT = 10'h000;
  localparam logic [7:0] SELECT_WMASK = 8'hef;
  // ==========================================
  // reference codes
  localparam logic [1:0] REF_EXTERNAL = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_RESERVED = 2'h2;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  // ==========================================
  // channel codes
  localparam logic [3:0] CH_LAST_INPUT = 4'ha;
  localparam logic [3:0] CH_AMPLIFIER_ZERO_CHANNEL = 4'hb;
  localparam logic [3:0] CH_AMPLIFIER_ONE_CHANNEL = 4'hc;
  localparam logic [3:0] CH_RESERVED = 4'hd;
  localparam logic [3:0] CH_BANDGAP = 4'he;
  localparam logic [3:0] CH_GROUND = 4'hf;
  // ==========================================
  // types
  typedef struct packed {
    logic [1:0] ref_sel;
    logic result_left_align;
    logic unused_b4;
    logic [3:0] channel;
  } arsel_select_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } arsel_state_e;
endpackage

/* File: verilog/arsel_top.sv */
// converter control: registers, input selection, result coding and alignment
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module arsel_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic core_done,
  input wire logic [9:0] core_code,
  output logic core_start,
  output logic core_enable,
  output logic [1:0] active_ref_sel,
  output logic [3:0] active_channel,
  output logic active_differential,
  output logic ref_external_on,
  output logic ref_supply_on,
  output logic ref_internal_on,
  output logic amp_short_on
);

  // ==========================================
  // state
  arsel_pkg::arsel_state_e state_ff, nxt_state;
  logic enable_ff, nxt_enable;
  logic start_ff, nxt_start;
  logic done_ff, nxt_done;
  logic mask_ff, nxt_mask;
  logic amp_short_ff, nxt_amp_short;
  arsel_pkg::arsel_select_s select_ff, nxt_select;
  arsel_pkg::arsel_select_s active_ff, nxt_active;
  logic [9:0] result_ff, nxt_result;
  logic start_pulse_ff, nxt_start_pulse;
  logic [7:0] rdata_ff, nxt_rdata;

  // ==========================================
  // decoding
  function automatic logic is_diff(input logic [3:0] ch);
    is_diff = (ch == arsel_pkg::CH_AMPLIFIER_ZERO_CHANNEL) || (ch == arsel_pkg::CH_AMPLIFIER_ONE_CHANNEL);
  endfunction

  logic wr_a;
  logic wr_b;
  logic wr_sel;
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  logic [9:0] coded;

  assign wr_a = reg_wr && (reg_addr == arsel_pkg::OFF_CTRL_A);
  assign wr_b = reg_wr && (reg_addr == arsel_pkg::OFF_CTRL_B);
  assign wr_sel = reg_wr && (reg_addr == arsel_pkg::OFF_SELECT);

  // result coding per active channel kind
  always_comb begin
    if (is_diff(active_ff.channel)) begin
      coded = {~core_code[9], core_code[8:0]};
    end else begin
      coded = core_code;
    end
  end

  // byte layout follows the live alignment bit
  always_comb begin
    if (select_ff.result_left_align) begin
      res_hi = result_ff[9:2];
      res_lo = {result_ff[1:0], 6'h00};
    end else begin
      res_hi = {6'h00, result_ff[9:8]};
      res_lo = result_ff[7:0];
    end
  end

  // ==========================================
  // register file and sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_enable = enable_ff;
    nxt_start = start_ff;
    nxt_done = done_ff;
    nxt_mask = mask_ff;
    nxt_amp_short = amp_short_ff;
    nxt_select = select_ff;
    nxt_active = active_ff;
    nxt_result = result_ff;
    nxt_start_pulse = 1'b0;
    if (wr_a) begin
      nxt_enable = reg_wdata[arsel_pkg::CA_ENABLE];
      nxt_mask = reg_wdata[arsel_pkg::CA_DONE_MASK];
      if (reg_wdata[arsel_pkg::CA_START]) begin
        nxt_start = 1'b1;
      end
      if (reg_wdata[arsel_pkg::CA_DONE]) begin
        nxt_done = 1'b0;
      end
    end
    if (wr_b) begin
      nxt_amp_short = reg_wdata[arsel_pkg::CB_AMP_SHORT];
    end
    if (wr_sel) begin
      nxt_select = reg_wdata & arsel_pkg::SELECT_WMASK;
    end
    unique case (state_ff)
      arsel_pkg::ST_IDLE: begin
        nxt_active = nxt_select;
        if (nxt_start && nxt_enable) begin
          nxt_state = arsel_pkg::ST_CONV;
          nxt_start_pulse = 1'b1;
        end else begin
          nxt_start = 1'b0;
        end
      end
      arsel_pkg::ST_CONV: begin
        if (core_done) begin
          nxt_result = coded;
          nxt_done = 1'b1;
          nxt_start = 1'b0;
          nxt_active = nxt_select;
          nxt_state = arsel_pkg::ST_IDLE;
        end
      end
    endcase
    if (nxt_state == arsel_pkg::ST_IDLE) begin
      nxt_active.unused_b4 = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= arsel_pkg::ST_IDLE;
      enable_ff <= arsel_pkg::RST_CTRL_A[arsel_pkg::CA_ENABLE];
      start_ff <= arsel_pkg::RST_CTRL_A[arsel_pkg::CA_START];
      done_ff <= arsel_pkg::RST_CTRL_A[arsel_pkg::CA_DONE];
      mask_ff <= arsel_pkg::RST_CTRL_A[arsel_pkg::CA_DONE_MASK];
      amp_short_ff <= arsel_pkg::RST_CTRL_B[arsel_pkg::CB_AMP_SHORT];
      select_ff <= arsel_pkg::RST_SELECT;
      active_ff <= arsel_pkg::RST_SELECT;
      result_ff <= arsel_pkg::RST_RESULT;
      start_pulse_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      enable_ff <= nxt_enable;
      start_ff <= nxt_start;
      done_ff <= nxt_done;
      mask_ff <= nxt_mask;
      amp_short_ff <= nxt_amp_short;
      select_ff <= nxt_select;
      active_ff <= nxt_active;
      result_ff <= nxt_result;
      start_pulse_ff <= nxt_start_pulse;
    end
  end

  // ==========================================
  // read port
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        arsel_pkg::OFF_CTRL_A: begin
          nxt_rdata = {enable_ff, start_ff, 1'b0, done_ff, mask_ff, 3'h0};
        end
        arsel_pkg::OFF_CTRL_B: begin
          nxt_rdata = {7'h00, amp_short_ff};
        end
        arsel_pkg::OFF_SELECT: begin
          nxt_rdata = select_ff;
        end
        arsel_pkg::OFF_RES_LO: begin
          nxt_rdata = res_lo;
        end
        arsel_pkg::OFF_RES_HI: begin
          nxt_rdata = res_hi;
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================
  // outputs
  assign reg_rdata = rdata_ff;
  assign irq = done_ff && mask_ff;
  assign core_start = start_pulse_ff;
  assign core_enable = enable_ff || (state_ff == arsel_pkg::ST_CONV);
  assign active_ref_sel = active_ff.ref_sel;
  assign active_channel = active_ff.channel;
  assign active_differential = is_diff(active_ff.channel);
  assign ref_external_on = (active_ff.ref_sel == arsel_pkg::REF_EXTERNAL);
  assign ref_supply_on = (active_ff.ref_sel == arsel_pkg::REF_SUPPLY);
  assign ref_internal_on = (active_ff.ref_sel == arsel_pkg::REF_INTERNAL) && core_enable;
  assign amp_short_on = amp_short_ff && is_diff(active_ff.channel);

endmodule
`default_nettype wire

/* File: test/arsel_assertions.sv */
// checker for the converter result and input select block
`timescale 1ns/1ns
`default_nettype none
module arsel_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic core_done,
  input wire logic core_start,
  input wire logic core_enable,
  input wire logic [1:0] active_ref_sel,
  input wire logic [3:0] active_channel,
  input wire logic active_differential,
  input wire logic ref_external_on,
  input wire logic ref_supply_on,
  input wire logic ref_internal_on,
  input wire logic amp_short_on
);
  logic conv_ff;
  logic nxt_conv;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // conversion tracking
  always_comb begin
    nxt_conv = (conv_ff | core_start) & ~(conv_ff & core_done);
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      conv_ff <= 1'b0;
    end else begin
      conv_ff <= nxt_conv;
    end
  end
  sequence s_busy;
    conv_ff && !core_done;
  endsequence
  sequence s_held;
    $stable(active_channel) && $stable(active_ref_sel);
  endsequence
  // ==========================================
  // properties
  chk_sel_locked: assert property (s_busy |=> s_held)
    else $error("selection moved mid conversion");
  chk_busy_enable: assert property (s_busy |-> core_enable)
    else $error("converter disabled while busy");
  chk_rd_quiet: assert property ((!reg_rd || reg_addr > 3'h4) |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  chk_ref_ext: assert property (ref_external_on == (active_ref_sel == 2'h0))
    else $error("external reference decode");
  chk_ref_supply: assert property (ref_supply_on == (active_ref_sel == 2'h1))
    else $error("supply reference decode");
  chk_ref_int: assert property (ref_internal_on == (active_ref_sel == 2'h3 && core_enable))
    else $error("internal reference decode");
  chk_diff_dec: assert property (active_differential == (active_channel inside {4'hb, 4'hc}))
    else $error("differential decode");
  chk_short_diff: assert property (amp_short_on |-> active_differential)
    else $error("short on single ended");
  chk_start_pulse: assert property ($rose(core_start) |-> core_enable ##1 !core_start)
    else $error("start not a pulse");
endmodule
bind arsel_top arsel_chk u_chk (.clock, .rst_b, .reg_addr, .reg_rd, .reg_rdata, .core_done,
  .core_start, .core_enable, .active_ref_sel, .active_channel, .active_differential,
  .ref_external_on, .ref_supply_on, .ref_internal_on, .amp_short_on);
`default_nettype wire

/* File: test/test_adc_result_and_input_select.sv */
// self-checking bench for the converter result and input select block
`timescale 1ns/1ns
`default_nettype none
module test_adc_result_and_input_select;
  logic clock, rst_b, reg_wr, reg_rd, irq, core_done, core_start, core_enable;
  logic active_differential, ref_external_on, ref_supply_on, ref_internal_on, amp_short_on;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, sel;
  logic [9:0] core_code, raw, res;
  logic [1:0] active_ref_sel;
  logic [3:0] active_channel;
  logic diff;
  int err_total = 0;
  int n_tests = 0;
  int seed = 51;
  int i;
  arsel_top dut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .core_done, .core_code, .core_start, .core_enable, .active_ref_sel, .active_channel,
    .active_differential, .ref_external_on, .ref_supply_on, .ref_internal_on, .amp_short_on);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check(what, {2'h0, reg_rdata}, {2'h0, exp});
  endtask
  task automatic finish_conv(input logic [9:0] r);
    @(posedge clock);
    core_code <= r;
    core_done <= 1'b1;
    @(posedge clock);
    core_done <= 1'b0;
    core_code <= ~r;
    #1;
  endtask
  function automatic logic [9:0] coded(input logic [9:0] r, input logic d);
    return d ? {~r[9], r[8:0]} : r;
  endfunction
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, core_done} = 4'h0;
    {reg_addr, reg_wdata, core_code} = 21'h000000;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    rd(3'h2, 8'h00, "select reset");
    rd(3'h7, 8'h00, "unmapped");
    check("ext ref", {9'h000, ref_external_on}, 10'h001);
    $display("reset test done");
    wr(3'h1, 8'h01);
    for (i = 0; i < 16; i++) begin
      sel = 8'($random(seed));
      sel[3:0] = i[3:0];
      raw = (i == 0 || i == 11) ? 10'h000 : (i == 1 || i == 12) ? 10'h3ff : 10'($random(seed));
      diff = (i == 11 || i == 12);
      res = coded(raw, diff);
      wr(3'h2, sel);
      rd(3'h2, sel & 8'hef, "select");
      wr(3'h0, {4'hc, i[0], 3'h0});
      repeat (2) @(posedge clock);
      finish_conv(raw);
      check("channel", {6'h00, active_channel}, {6'h00, i[3:0]});
      check("int ref", {9'h000, ref_internal_on}, {9'h000, sel[7:6] == 2'h3});
      check("short", {9'h000, amp_short_on}, {9'h000, diff});
      check("irq", {9'h000, irq}, {9'h000, i[0]});
      rd(3'h4, sel[5] ? res[9:2] : {6'h00, res[9:8]}, "result hi");
      rd(3'h3, sel[5] ? {res[1:0], 6'h00} : res[7:0], "result lo");
      rd(3'h0, {4'h9, i[0], 3'h0}, "status");
      wr(3'h2, sel ^ 8'h20);
      rd(3'h4, sel[5] ? {6'h00, res[9:8]} : res[9:2], "realigned hi");
      wr(3'h0, {4'h9, i[0], 3'h0});
      rd(3'h0, {4'h8, i[0], 3'h0}, "flag cleared");
      $display("test %0d done", i);
    end
    wr(3'h2, 8'h41);
    wr(3'h0, 8'hc0);
    wr(3'h2, 8'h05);
    #1 check("locked ch", {6'h00, active_channel}, 10'h001);
    check("locked ref", {8'h00, active_ref_sel}, 10'h001);
    finish_conv(10'h155);
    check("new ch", {6'h00, active_channel}, 10'h005);
    check("new ref", {8'h00, active_ref_sel}, 10'h000);
    $display("lock test done");
    print_verdict();
  end
endmodule
`default_nettype wire
